// *** common/fbm_pkg.sv ***
// shared types and constants of the fieldbus master state sequencer
// assumes a 200 MHz clock and a slave that answers each command once
package fbm_pkg;

  // ************************************************************
  // application states of the slave, lowest first
  // ************************************************************
  typedef enum logic [2:0] {
    FBM_INIT, FBM_PREOP, FBM_SAFEOP, FBM_OP, FBM_BOOT
  } fbm_app_e;

  typedef enum logic [2:0] {
    FBM_CMD_CFG, FBM_CMD_STATE, FBM_CMD_MBX_RD, FBM_CMD_MBX_WR
  } fbm_cmd_e;

  typedef enum logic [2:0] {
    FBM_CFG_ADDR, FBM_CFG_MBXP, FBM_CFG_DCLK,
    FBM_CFG_MAP, FBM_CFG_SMCH, FBM_CFG_FMMU
  } fbm_cfg_e;

  typedef enum logic [2:0] {
    FBM_SQ_IDLE, FBM_SQ_STEP, FBM_SQ_CFG, FBM_SQ_REQ, FBM_SQ_WAIT,
    FBM_SQ_MWAIT
  } fbm_seq_e;

  // ************************************************************
  // link carriers
  // ************************************************************
  typedef struct packed {
    logic valid;
    fbm_cmd_e cmd;
    fbm_app_e state;
    fbm_cfg_e item;
    logic [15:0] data;
  } fbm_cmd_s;

  typedef struct packed {
    logic valid;
    fbm_app_e state;
    logic err;
    logic [1:0] wkc;
    logic [15:0] data;
    logic mbx_full;
  } fbm_ans_s;

  typedef struct packed {
    logic valid;
    logic out_valid;
    logic [15:0] out_data;
  } fbm_frame_s;

  typedef logic [4:0] fbm_addr_t;

  // ************************************************************
  // register map and fields
  // ************************************************************
  localparam fbm_addr_t FBM_REG_CTRL = 5'h00;
  localparam fbm_addr_t FBM_REG_STAT = 5'h04;
  localparam fbm_addr_t FBM_REG_CFG = 5'h08;
  localparam fbm_addr_t FBM_REG_TX = 5'h0C;
  localparam fbm_addr_t FBM_REG_RX = 5'h10;
  localparam fbm_addr_t FBM_REG_OUT = 5'h14;
  localparam int FBM_CTRL_TGT_LSB = 0;
  localparam int FBM_CTRL_GO_BIT = 3;
  localparam int FBM_CTRL_MBX_EN_BIT = 4;
  localparam int FBM_CTRL_DC_EN_BIT = 5;
  localparam int FBM_STAT_BUSY_BIT = 4;
  localparam int FBM_STAT_ERR_BIT = 5;
  localparam int FBM_STAT_RXV_BIT = 6;
  localparam int FBM_STAT_TXP_BIT = 7;
  localparam int FBM_STAT_SLV_ERR_BIT = 8;
  localparam logic [31:0] FBM_CFG_RESET = 32'h0000_0000;
  localparam logic [1:0] FBM_WKC_OK = 2'h1;
  localparam logic [1:0] FBM_CFG_ITEMS = 2'h3;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int FBM_CLK_NS = 5;
  localparam int FBM_FRAME_NS = 1000;
  localparam int FBM_ANS_TIMEOUT_NS = 10000;
  localparam logic [11:0] FBM_FRAME_CYC = 12'(FBM_FRAME_NS / FBM_CLK_NS);
  localparam logic [11:0] FBM_ANS_CYC =
    12'(FBM_ANS_TIMEOUT_NS / FBM_CLK_NS);
  localparam logic [1:0] FBM_OP_LEAD_FRAMES = 2'h2;

endpackage

// *** hdl/fbm_step.sv ***
// next legal single transition toward a target application state
// purely combinational; the caller holds current and target stable
module fbm_step
  import fbm_pkg::*;
(
  input fbm_pkg::fbm_app_e cur,
  input fbm_pkg::fbm_app_e target,
  output fbm_pkg::fbm_app_e next,
  output logic legal
);

  // ************************************************************
  // transition choice
  // ************************************************************
  always_comb begin
    next = cur;
    legal = 1'b1;
    if (cur == target) begin
      next = cur;
    end else if (target == FBM_BOOT) begin
      legal = (cur == FBM_INIT);
      next = FBM_BOOT;
    end else if (cur == FBM_BOOT) begin
      legal = (target == FBM_INIT);
      next = FBM_INIT;
    end else if (cur == FBM_OP) begin
      // only the top state may jump straight down
      next = target;
    end else if (target > cur) begin
      next = fbm_app_e'(cur + 3'h1);
    end else begin
      next = fbm_app_e'(cur - 3'h1);
    end
  end

endmodule

// *** hdl/fbm_master.sv ***
// fieldbus master: sequences slave application states and mailboxes
// assumes an Avalon-MM master on the register side and a slave that
// answers every command with one ans.valid pulse
//
// Function
// - going up, step init, pre-op, safe-op, op without skipping
// - skipping allowed only when leaving op downward; else adjacent
// - boot-strap reached only from init and left only to init
// - every state change starts with a master state command
// - program address, mailbox, clock registers before pre-op request
// - set mapping, sync channels, fmmu before safe-op request
// - send valid output frames in safe-op before requesting op, except after a drop from op to safe-op
// - read the filled input mailbox as soon as possible
// - detect a full input mailbox by periodic flag polling
// - mailbox read with counter 1 means new data present
// - mailbox write succeeds only with counter 1; else repeat
module fbm_master
  import fbm_pkg::*;
(
  input logic clk,
  input logic resetn,
  input fbm_pkg::fbm_addr_t avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output fbm_pkg::fbm_cmd_s cmd,
  input fbm_pkg::fbm_ans_s ans,
  output fbm_pkg::fbm_frame_s frame
);
  import fbm_pkg::*;

  // ************************************************************
  // declarations
  // ************************************************************
  fbm_seq_e seq;
  fbm_app_e cur;
  fbm_app_e tgt;
  fbm_app_e step;
  logic step_ok;
  logic mbx_en;
  logic dc_en;
  logic [31:0] cfg_word;
  logic [15:0] tx_data;
  logic [15:0] rx_data;
  logic [15:0] out_data;
  logic busy;
  logic err;
  logic slv_err;
  logic rx_valid;
  logic tx_pend;
  logic rd_pend;
  logic wait_cfg;
  logic mbx_rd_wait;
  logic [1:0] cfg_idx;
  logic [11:0] ans_cnt;
  logic [11:0] frame_cnt;
  logic [1:0] lead_cnt;
  logic wr_hit;
  logic rd_hit;
  logic go;
  logic mbx_ok;
  logic frames_ok;
  logic tick;
  logic timeout;
  logic [31:0] rd_mux;
  logic [31:0] wr_ctrl;
  fbm_cfg_e item;
  logic item_need;

  function automatic logic [31:0] be_merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  fbm_step u_step (
    .cur(cur),
    .target(tgt),
    .next(step),
    .legal(step_ok)
  );

  // ************************************************************
  // register bus
  // ************************************************************
  // waitrequest idles high; a request is answered one cycle later
  assign wr_hit = avs_write && !avs_waitrequest;
  assign rd_hit = avs_read && !avs_waitrequest;
  assign wr_ctrl = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
  assign go = wr_hit && (avs_address == FBM_REG_CTRL) &&
              wr_ctrl[FBM_CTRL_GO_BIT];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      FBM_REG_CTRL: begin
        rd_mux[FBM_CTRL_TGT_LSB +: 3] = tgt;
        rd_mux[FBM_CTRL_MBX_EN_BIT] = mbx_en;
        rd_mux[FBM_CTRL_DC_EN_BIT] = dc_en;
      end
      FBM_REG_STAT: begin
        rd_mux[2:0] = cur;
        rd_mux[FBM_STAT_BUSY_BIT] = busy;
        rd_mux[FBM_STAT_ERR_BIT] = err;
        rd_mux[FBM_STAT_RXV_BIT] = rx_valid;
        rd_mux[FBM_STAT_TXP_BIT] = tx_pend;
        rd_mux[FBM_STAT_SLV_ERR_BIT] = slv_err;
      end
      FBM_REG_CFG: rd_mux = cfg_word;
      FBM_REG_TX: rd_mux[15:0] = tx_data;
      FBM_REG_RX: rd_mux[15:0] = rx_data;
      FBM_REG_OUT: rd_mux[15:0] = out_data;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_mux;
    end
  end

  // software settings; target and options change on every CTRL write with byte lane 0 enabled, go or not
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tgt <= FBM_INIT;
      mbx_en <= 1'b0;
      dc_en <= 1'b0;
      cfg_word <= FBM_CFG_RESET;
      tx_data <= 16'h0000;
      out_data <= 16'h0000;
    end else if (wr_hit) begin
      case (avs_address)
        FBM_REG_CTRL: begin
          if (avs_byteenable[0]) begin
            tgt <= fbm_app_e'(wr_ctrl[FBM_CTRL_TGT_LSB +: 3]);
            mbx_en <= wr_ctrl[FBM_CTRL_MBX_EN_BIT];
            dc_en <= wr_ctrl[FBM_CTRL_DC_EN_BIT];
          end
        end
        FBM_REG_CFG: cfg_word <= be_merge(cfg_word, avs_writedata,
                                          avs_byteenable);
        FBM_REG_TX: tx_data <= 16'(be_merge({16'h0000, tx_data},
                                            avs_writedata,
                                            avs_byteenable));
        FBM_REG_OUT: out_data <= 16'(be_merge({16'h0000, out_data},
                                              avs_writedata,
                                              avs_byteenable));
        default: ;
      endcase
    end
  end

  // ************************************************************
  // cyclic frames and mailbox polling
  // ************************************************************
  // init carries no application traffic, pre-op only mailbox
  assign mbx_ok = (cur != FBM_INIT);
  assign frames_ok = (cur == FBM_SAFEOP) || (cur == FBM_OP);
  assign tick = (frame_cnt == FBM_FRAME_CYC - 12'h001);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      frame_cnt <= 12'h000;
    end else if (tick) begin
      frame_cnt <= 12'h000;
    end else begin
      frame_cnt <= frame_cnt + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      frame <= '0;
    end else begin
      frame.valid <= tick && frames_ok;
      // valid output data already flows in safe-op, ahead of op
      frame.out_valid <= frames_ok;
      frame.out_data <= frames_ok ? out_data : 16'h0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      lead_cnt <= 2'h0;
    end else if (!frames_ok) begin
      lead_cnt <= 2'h0;
    end else if (tick && lead_cnt != FBM_OP_LEAD_FRAMES) begin
      lead_cnt <= lead_cnt + 2'h1;
    end
  end

  // ************************************************************
  // configuration item table
  // ************************************************************
  always_comb begin
    item = FBM_CFG_ADDR;
    item_need = 1'b0;
    if (step == FBM_PREOP && cur == FBM_INIT) begin
      case (cfg_idx)
        2'h0: begin
          item = FBM_CFG_ADDR;
          item_need = 1'b1;
        end
        2'h1: begin
          item = FBM_CFG_MBXP;
          item_need = mbx_en;
        end
        2'h2: begin
          item = FBM_CFG_DCLK;
          item_need = dc_en;
        end
        default: item_need = 1'b0;
      endcase
    end else if (step == FBM_SAFEOP && cur == FBM_PREOP) begin
      case (cfg_idx)
        2'h0: item = FBM_CFG_MAP;
        2'h1: item = FBM_CFG_SMCH;
        2'h2: item = FBM_CFG_FMMU;
        default: item = FBM_CFG_ADDR;
      endcase
      item_need = (cfg_idx != FBM_CFG_ITEMS);
    end
  end

  assign timeout = (ans_cnt == FBM_ANS_CYC);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ans_cnt <= 12'h000;
    end else if (seq == FBM_SQ_WAIT || seq == FBM_SQ_MWAIT) begin
      ans_cnt <= ans_cnt + 12'h001;
    end else begin
      ans_cnt <= 12'h000;
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  // a slave that never answers is given up on; err tells software for state and set-up commands, mailbox waits end silently
  always_ff @(posedge clk) begin
    if (!resetn) begin
      seq <= FBM_SQ_IDLE;
      cur <= FBM_INIT;
      cmd <= '0;
      busy <= 1'b0;
      err <= 1'b0;
      slv_err <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 16'h0000;
      tx_pend <= 1'b0;
      rd_pend <= 1'b0;
      wait_cfg <= 1'b0;
      mbx_rd_wait <= 1'b0;
      cfg_idx <= 2'h0;
    end else begin
      cmd.valid <= 1'b0;
      if (go) begin
        busy <= 1'b1;
        err <= 1'b0;
        slv_err <= 1'b0;
      end
      if (wr_hit && avs_address == FBM_REG_TX) begin
        tx_pend <= 1'b1;
      end
      if (rd_hit && avs_address == FBM_REG_RX) begin
        rx_valid <= 1'b0;
      end
      case (seq)
        FBM_SQ_IDLE: begin
          if (rd_pend && mbx_ok) begin
            cmd.valid <= 1'b1;
            cmd.cmd <= FBM_CMD_MBX_RD;
            mbx_rd_wait <= 1'b1;
            seq <= FBM_SQ_MWAIT;
          end else if (busy && !go) begin
            seq <= FBM_SQ_STEP;
          end else if (tx_pend && mbx_ok) begin
            // in boot-strap this carries the firmware image
            cmd.valid <= 1'b1;
            cmd.cmd <= FBM_CMD_MBX_WR;
            cmd.data <= tx_data;
            mbx_rd_wait <= 1'b0;
            seq <= FBM_SQ_MWAIT;
          end
        end
        FBM_SQ_STEP: begin
          cfg_idx <= 2'h0;
          if (cur == tgt) begin
            busy <= 1'b0;
            seq <= FBM_SQ_IDLE;
          end else if (!step_ok) begin
            err <= 1'b1;
            busy <= 1'b0;
            seq <= FBM_SQ_IDLE;
          end else begin
            seq <= FBM_SQ_CFG;
          end
        end
        FBM_SQ_CFG: begin
          if (step == FBM_OP) begin
            if (lead_cnt == FBM_OP_LEAD_FRAMES) begin
              seq <= FBM_SQ_REQ;
            end
          end else if (cfg_idx == FBM_CFG_ITEMS) begin
            seq <= FBM_SQ_REQ;
          end else if (item_need) begin
            cmd.valid <= 1'b1;
            cmd.cmd <= FBM_CMD_CFG;
            cmd.item <= item;
            cmd.data <= (item == FBM_CFG_ADDR) ? cfg_word[15:0] :
                        cfg_word[31:16];
            wait_cfg <= 1'b1;
            seq <= FBM_SQ_WAIT;
          end else begin
            cfg_idx <= cfg_idx + 2'h1;
          end
        end
        FBM_SQ_REQ: begin
          cmd.valid <= 1'b1;
          cmd.cmd <= FBM_CMD_STATE;
          cmd.state <= step;
          wait_cfg <= 1'b0;
          seq <= FBM_SQ_WAIT;
        end
        FBM_SQ_WAIT: begin
          if (ans.valid) begin
            if (wait_cfg) begin
              cfg_idx <= cfg_idx + 2'h1;
              seq <= FBM_SQ_CFG;
            end else begin
              cur <= ans.state;
              if (ans.err || ans.state != step) begin
                err <= 1'b1;
                slv_err <= ans.err;
                busy <= 1'b0;
              end
              seq <= FBM_SQ_IDLE;
            end
          end else if (timeout) begin
            err <= 1'b1;
            busy <= 1'b0;
            seq <= FBM_SQ_IDLE;
          end
        end
        FBM_SQ_MWAIT: begin
          if (ans.valid) begin
            if (mbx_rd_wait) begin
              // a counter of one is the only proof of fresh data
              if (ans.wkc == FBM_WKC_OK) begin
                rx_data <= ans.data;
                rx_valid <= 1'b1;
              end
              rd_pend <= 1'b0;
            end else if (ans.wkc == FBM_WKC_OK &&
                         !(wr_hit && avs_address == FBM_REG_TX)) begin
              tx_pend <= 1'b0;
            end
            seq <= FBM_SQ_IDLE;
          end else if (timeout) begin
            seq <= FBM_SQ_IDLE;
          end
        end
        default: seq <= FBM_SQ_IDLE;
      endcase
      // a poll landing with an answer wins; at worst one empty read
      if (tick && mbx_ok && ans.mbx_full) begin
        rd_pend <= 1'b1;
      end
    end
  end

endmodule

// *** test/fbm_slave_model.sv ***
// slave model: application states and one input mailbox
// assumes the master keeps one command outstanding on cmd
module fbm_slave_model
  import fbm_pkg::*;
#(
  parameter logic [15:0] MBX_WORD = 16'h5A3C,
  parameter logic [3:0] NACKS = 4'h2
)
(
  input logic clk,
  input logic resetn,
  input fbm_pkg::fbm_cmd_s cmd,
  output fbm_pkg::fbm_ans_s ans,
  input fbm_pkg::fbm_frame_s frame,
  input logic slow,
  input logic bad,
  input logic fill,
  output logic [15:0] outputs,
  output logic [15:0] wr_data,
  output logic [3:0] wr_cnt
);
  fbm_app_e st;
  fbm_cmd_s c;
  logic pend;
  logic full;
  logic [4:0] cnt;

  function automatic logic legal(fbm_app_e f, fbm_app_e t);
    if (t == FBM_BOOT || f == FBM_BOOT)
      return (f == FBM_INIT) || (t == FBM_INIT);
    return (f == FBM_OP && t < f) || (t == f + 1) || (t + 1 == f);
  endfunction

  // ***
  // answers, prompt or slow
  // ***
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= FBM_INIT;
      pend <= 1'b0;
      full <= 1'b0;
      ans <= '0;
      wr_cnt <= 4'h0;
      wr_data <= 16'h0;
    end else begin
      ans.valid <= 1'b0;
      ans.mbx_full <= full;
      // idle fields toggle so a stale sample cannot pass
      ans.data <= ~ans.data;
      ans.wkc <= ~ans.wkc;
      if (fill) begin
        full <= 1'b1;
      end
      if (cmd.valid) begin
        c <= cmd;
        pend <= 1'b1;
        cnt <= slow ? 5'h14 : 5'h01;
      end else if (pend && cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end else if (pend) begin
        pend <= 1'b0;
        ans.valid <= 1'b1;
        ans.state <= st;
        ans.err <= 1'b0;
        ans.wkc <= 2'h0;
        ans.data <= 16'h0000;
        case (c.cmd)
          FBM_CMD_CFG: ans.wkc <= 2'h1;
          FBM_CMD_STATE: begin
            if (bad || !legal(st, c.state)) begin
              ans.err <= 1'b1;
            end else begin
              st <= c.state;
              ans.state <= c.state;
            end
          end
          FBM_CMD_MBX_RD: begin
            if (st != FBM_INIT && full) begin
              ans.wkc <= 2'h1;
              ans.data <= MBX_WORD;
              full <= 1'b0;
            end
          end
          FBM_CMD_MBX_WR: begin
            wr_cnt <= wr_cnt + 4'h1;
            if (st != FBM_INIT && wr_cnt >= NACKS) begin
              ans.wkc <= 2'h1;
              wr_data <= c.data;
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || st != FBM_OP) begin
      outputs <= 16'h0000;
    end else if (frame.valid && frame.out_valid) begin
      outputs <= frame.out_data;
    end
  end
endmodule

// *** test/fbm_master_chk.sv ***
// port checker for the fieldbus master
// assumes one clock and a synchronous active-low reset
module fbm_master_chk
  import fbm_pkg::*;
(
  input logic clk,
  input logic resetn,
  input fbm_pkg::fbm_addr_t avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input fbm_pkg::fbm_cmd_s cmd,
  input fbm_pkg::fbm_ans_s ans,
  input fbm_pkg::fbm_frame_s frame
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  fbm_app_e cur;
  logic [5:0] seen;
  logic [1:0] fcnt;
  logic [9:0] wait_rd;
  logic sc;
  assign sc = cmd.valid && cmd.cmd == FBM_CMD_STATE;

  // ***
  // slave state and set-up seen since the last state request
  // ***
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cur <= FBM_INIT;
      seen <= 6'h00;
      fcnt <= 2'h0;
      wait_rd <= 10'h000;
    end else begin
      if (ans.valid && cmd.cmd == FBM_CMD_STATE) cur <= ans.state;
      if (sc) begin
        seen <= 6'h00;
        fcnt <= 2'h0;
      end else begin
        if (cmd.valid && cmd.cmd == FBM_CMD_CFG) seen[cmd.item] <= 1'b1;
        if (frame.valid && fcnt != 2'h3) fcnt <= fcnt + 2'h1;
      end
      if (!ans.mbx_full || !(cur inside {FBM_SAFEOP, FBM_OP}) ||
          (cmd.valid && cmd.cmd == FBM_CMD_MBX_RD))
        wait_rd <= 10'h000;
      else
        wait_rd <= wait_rd + 10'h001;
    end
  end

  property p_up;
    sc && cmd.state > cur && cmd.state != FBM_BOOT && cur != FBM_BOOT
      |-> cmd.state == cur + 1;
  endproperty
  a_up: assert property (p_up)
    else $error("upward request skips a state");
  property p_down;
    sc && cmd.state < cur && !(cur inside {FBM_OP, FBM_BOOT})
      |-> cmd.state + 1 == cur;
  endproperty
  a_down: assert property (p_down)
    else $error("downward skip not from operational");
  property p_boot;
    sc && (cmd.state == FBM_BOOT || cur == FBM_BOOT)
      |-> cur == FBM_INIT || cmd.state == FBM_INIT;
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot-strap move not via init");
  property p_init_mbx;
    cmd.valid && cur == FBM_INIT
      |-> cmd.cmd inside {FBM_CMD_CFG, FBM_CMD_STATE};
  endproperty
  a_init_mbx: assert property (p_init_mbx)
    else $error("mailbox command in init");
  property p_frame;
    frame.valid |-> cur inside {FBM_SAFEOP, FBM_OP} ||
      $past(cur) inside {FBM_SAFEOP, FBM_OP};
  endproperty
  a_frame: assert property (p_frame)
    else $error("process data frame outside safe-op or op");
  property p_ip_cfg;
    sc && cmd.state == FBM_PREOP && cur == FBM_INIT
      |-> seen[FBM_CFG_ADDR] && seen[FBM_CFG_MBXP] && seen[FBM_CFG_DCLK];
  endproperty
  a_ip_cfg: assert property (p_ip_cfg)
    else $error("pre-op requested before set-up");
  property p_ps_cfg;
    sc && cmd.state == FBM_SAFEOP && cur == FBM_PREOP
      |-> seen[FBM_CFG_MAP] && seen[FBM_CFG_SMCH] && seen[FBM_CFG_FMMU];
  endproperty
  a_ps_cfg: assert property (p_ps_cfg)
    else $error("safe-op requested before mapping set-up");
  property p_op_lead;
    sc && cmd.state == FBM_OP && cur == FBM_SAFEOP
      |-> fcnt >= FBM_OP_LEAD_FRAMES;
  endproperty
  a_op_lead: assert property (p_op_lead)
    else $error("op requested before output frames");
  property p_mbx_rd;
    wait_rd < 10'd500;
  endproperty
  a_mbx_rd: assert property (p_mbx_rd)
    else $error("full input mailbox not read");
  property p_retry;
    ans.valid && cmd.cmd == FBM_CMD_MBX_WR && ans.wkc != FBM_WKC_OK
      |-> ##[2:60] (cmd.valid && cmd.cmd == FBM_CMD_MBX_WR);
  endproperty
  a_retry: assert property (p_retry)
    else $error("failed mailbox write not repeated");
  property p_bus;
    (avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus answer not one cycle after request");

  c_op: cover property (sc && cmd.state == FBM_OP);
  c_rd: cover property (ans.valid && cmd.cmd == FBM_CMD_MBX_RD);
  c_err: cover property (ans.valid && ans.err);
endmodule

bind fbm_master fbm_master_chk chk (.clk(clk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .cmd(cmd), .ans(ans),
  .frame(frame));

// *** test/tb_fbm_master.sv ***
// testbench for the fieldbus master against the slave model
// assumes the bound port checker; 200 MHz clock
module tb_fbm_master;
  timeunit 1ns;
  timeprecision 1ps;
  import fbm_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  fbm_addr_t avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  fbm_cmd_s cmd;
  fbm_ans_s ans;
  fbm_frame_s frame;
  logic slow = 1'b0;
  logic bad = 1'b0;
  logic fill = 1'b0;
  logic [15:0] outputs;
  logic [15:0] wr_data;
  logic [3:0] wr_cnt;
  logic [31:0] rd;
  int miscompares = 0;
  int cmp_count = 0;

  fbm_master dut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cmd(cmd), .ans(ans), .frame(frame));
  fbm_slave_model u_slave (.clk(clk), .resetn(resetn), .cmd(cmd),
    .ans(ans), .frame(frame), .slow(slow), .bad(bad), .fill(fill),
    .outputs(outputs), .wr_data(wr_data), .wr_cnt(wr_cnt));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ***
  // shared bus and check tasks
  // ***
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask

  task automatic bus(input logic w, input fbm_addr_t a,
    input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("waitrequest", 32'h0, 32'(avs_waitrequest));
  endtask

  task automatic poll(input int b, input logic v);
    int k;
    k = 0;
    do begin
      bus(1'b0, FBM_REG_STAT, 32'h0, 4'hF);
      k++;
    end while (rd[b] !== v && k < 400);
  endtask

  // mailbox and clock support always announced
  task automatic go(input fbm_app_e t, input fbm_app_e e);
    bus(1'b1, FBM_REG_CTRL, 32'h38 | 32'(t), 4'h1);
    poll(FBM_STAT_BUSY_BIT, 1'b0);
    chk("state", 32'(e), 32'(rd[2:0]));
  endtask

  // ***
  // scenarios
  // ***
  task automatic t_idle;
    bus(1'b0, FBM_REG_STAT, 32'h0, 4'hF);
    chk("stat", 32'h0, rd);
    bus(1'b0, 5'h18, 32'h0, 4'hF);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, FBM_REG_CTRL, 32'h3A, 4'h0);
    fill <= 1'b1;
    @(posedge clk);
    fill <= 1'b0;
    repeat (600) @(posedge clk);
    bus(1'b0, FBM_REG_STAT, 32'h0, 4'hF);
    chk("idle state", 32'h0, 32'(rd[2:0]));
    chk("rx_valid", 32'h0, 32'(rd[FBM_STAT_RXV_BIT]));
  endtask

  task automatic t_boot;
    go(FBM_BOOT, FBM_BOOT);
    bus(1'b1, FBM_REG_TX, 32'h1234, 4'hF);
    poll(FBM_STAT_TXP_BIT, 1'b0);
    chk("wr_data", 32'h1234, 32'(wr_data));
    chk("wr_cnt", 32'h3, 32'(wr_cnt));
    go(FBM_PREOP, FBM_BOOT);
    chk("err", 32'h1, 32'(rd[FBM_STAT_ERR_BIT]));
    chk("slv_err", 32'h0, 32'(rd[FBM_STAT_SLV_ERR_BIT]));
    go(FBM_INIT, FBM_INIT);
  endtask

  task automatic t_fail;
    bad <= 1'b1;
    go(FBM_PREOP, FBM_INIT);
    chk("err", 32'h1, 32'(rd[FBM_STAT_ERR_BIT]));
    chk("slv_err", 32'h1, 32'(rd[FBM_STAT_SLV_ERR_BIT]));
    bad <= 1'b0;
  endtask

  task automatic t_up;
    slow <= 1'b1;
    go(FBM_SAFEOP, FBM_SAFEOP);
    chk("err", 32'h0, 32'(rd[FBM_STAT_ERR_BIT]));
    poll(FBM_STAT_RXV_BIT, 1'b1);
    bus(1'b0, FBM_REG_RX, 32'h0, 4'hF);
    chk("rx", 32'h5A3C, {16'h0, rd[15:0]});
    chk("outputs", 32'h0, 32'(outputs));
    slow <= 1'b0;
  endtask

  task automatic t_op;
    int f;
    f = 0;
    bus(1'b1, FBM_REG_OUT, 32'hC35A, 4'hF);
    go(FBM_OP, FBM_OP);
    fill <= 1'b1;
    @(posedge clk);
    fill <= 1'b0;
    repeat (210) @(posedge clk);
    chk("outputs", 32'hC35A, 32'(outputs));
    poll(FBM_STAT_RXV_BIT, 1'b1);
    chk("rx_valid op", 32'h1, 32'(rd[FBM_STAT_RXV_BIT]));
    go(FBM_INIT, FBM_INIT);
    repeat (400) begin
      @(posedge clk);
      if (frame.valid !== 1'b0) f++;
    end
    chk("frames", 32'h0, 32'(f));
  endtask

  task automatic results;
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_idle();
    t_boot();
    t_fail();
    t_up();
    t_op();
    results();
  end

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule
